// ==== verilog/lad_top.sv ====
// loss-of-signal and alarm detector with transmit pattern selection
// assumes line pins asynchronous to mclk; wishbone on mclk
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module lad_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // receive line side
  input  wire logic        rx_rclk,
  input  wire logic        rx_data_rails_p,
  input  wire logic        rx_data_rails_n,
  input  wire logic        lvl_below_q,
  input  wire logic        lvl_above_p,
  // threshold to the analog comparators
  output logic      [5:0]  q_atten_db,
  output logic      [5:0]  p_atten_db,
  output logic      [11:0] q_fixed_mv,
  output logic      [11:0] p_fixed_mv,
  output logic             eq_on_out,
  // receive system side
  output logic             rx_clk_out,
  output logic             rx_data_out,
  output logic             loss_indicator_out,
  output logic             loss_irq,
  // transmit side
  input  wire logic        tx_clk,
  input  wire logic        tx_data_in,
  output logic             tx_line_pair,
  output logic             tx_bit_stb
);
  // ***********************************************************
  // input synchronisers
  // ***********************************************************
  localparam int NS = 6;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] sync1_reg;
  logic [NS-1:0] sync2_reg;
  assign pin_raw = {tx_data_in, tx_clk, lvl_above_p, lvl_below_q,
                    rx_data_rails_n | rx_data_rails_p, rx_rclk};

  // first stage feeds only the second stage
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  logic rclk_s;
  logic mark_s;
  logic below_q;
  logic above_p;
  logic tclk_s;
  logic txd_s;
  assign rclk_s  = sync2_reg[0];
  assign mark_s  = sync2_reg[1];
  assign below_q = sync2_reg[2];
  assign above_p = sync2_reg[3];
  assign tclk_s  = sync2_reg[4];
  assign txd_s   = sync2_reg[5];

  // edge detection on the synchronised clocks
  logic rclk_d_reg;
  logic tclk_d_reg;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rclk_d_reg <= 1'b0;
      tclk_d_reg <= 1'b0;
    end else begin
      rclk_d_reg <= rclk_s;
      tclk_d_reg <= tclk_s;
    end
  end
  logic rx_bit;
  logic tx_en;
  logic pulse;
  assign rx_bit = rclk_s & ~rclk_d_reg;
  assign tx_en  = tclk_s & ~tclk_d_reg;
  assign pulse  = rx_bit & mark_s;

  // ***********************************************************
  // registers
  // ***********************************************************
  logic [31:0] ctrl_reg;
  logic [7:0]  code_reg;
  logic        los_reg;
  logic        ais_reg;
  logic        line_rate_sel;
  logic        los_standard_sel;
  logic        eq_on;
  logic        cdr_en;
  logic        rx_alarm_insert_en;
  logic        tx_alarm_insert_en;
  logic        pattern_clk_sel;
  logic        loss_mask;
  logic [1:0]  pattern_sel;
  logic [4:0]  loss_level_code;
  assign line_rate_sel      = ctrl_reg[lad_pkg::B_RATE];
  assign los_standard_sel   = ctrl_reg[lad_pkg::B_STD];
  assign eq_on              = ctrl_reg[lad_pkg::B_EQ];
  assign cdr_en             = ctrl_reg[lad_pkg::B_CDR];
  assign rx_alarm_insert_en = ctrl_reg[lad_pkg::B_RXINS];
  assign tx_alarm_insert_en = ctrl_reg[lad_pkg::B_TXINS];
  assign pattern_clk_sel    = ctrl_reg[lad_pkg::B_PCLK];
  assign loss_mask          = ctrl_reg[lad_pkg::B_MASK];
  assign pattern_sel        = ctrl_reg[lad_pkg::F_PAT +: 2];
  assign loss_level_code    = ctrl_reg[lad_pkg::F_LVL +: 5];

  logic wb_req;
  logic wb_wr;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i;

  // byte-lane writes; one-cycle ack, unmapped reads return zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= lad_pkg::CTRL_RST;
      code_reg <= lad_pkg::CODE_RST;
    end else if (wb_wr) begin
      if (wb_adr_i == lad_pkg::ADR_CTRL) begin
        for (int i = 0; i < 4; i++) begin
          if (wb_sel_i[i]) ctrl_reg[8*i +: 8] <= wb_dat_i[8*i +: 8];
        end
      end
      if (wb_adr_i == lad_pkg::ADR_CODE && wb_sel_i[0]) begin
        code_reg <= wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        case (wb_adr_i)
          lad_pkg::ADR_CTRL: wb_dat_o <= ctrl_reg;
          lad_pkg::ADR_CODE: wb_dat_o <= {24'h000000, code_reg};
          lad_pkg::ADR_STAT: wb_dat_o <= {30'h00000000, ais_reg, los_reg};
          default:           wb_dat_o <= '0;
        endcase
      end
    end
  end

  // ***********************************************************
  // criteria selection
  // ***********************************************************
  logic [lad_pkg::CW-1:0] n_lim;
  logic [lad_pkg::CW-1:0] m_lim;
  logic [7:0]             zrun_lim;
  always_comb begin
    case ({line_rate_sel, los_standard_sel})
      2'b10:   n_lim = lad_pkg::N_T1_231;
      2'b11:   n_lim = lad_pkg::N_T1_431;
      2'b00:   n_lim = lad_pkg::N_E1_775;
      default: n_lim = lad_pkg::N_E1_431;
    endcase
    m_lim    = line_rate_sel ? lad_pkg::M_T1 : lad_pkg::M_E1;
    zrun_lim = line_rate_sel ? lad_pkg::ZRUN_T1 : lad_pkg::ZRUN_E1;
  end

  // comparator thresholds; reserved level codes clamp to the top step
  logic [4:0] lvl_eff;
  assign lvl_eff = (loss_level_code > lad_pkg::LVL_MAX) ? lad_pkg::LVL_MAX : loss_level_code;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q_atten_db <= '0;
      p_atten_db <= '0;
      q_fixed_mv <= '0;
      p_fixed_mv <= '0;
      eq_on_out  <= 1'b0;
    end else begin
      eq_on_out  <= eq_on;
      q_fixed_mv <= lad_pkg::Q_FIX_MV;
      p_fixed_mv <= lad_pkg::Q_FIX_MV + lad_pkg::HYST_MV;
      q_atten_db <= lad_pkg::Q_BASE_DB + 6'(lvl_eff) * lad_pkg::Q_STEP_DB;
      p_atten_db <= lad_pkg::Q_BASE_DB + 6'(lvl_eff) * lad_pkg::Q_STEP_DB
                    - lad_pkg::HYST_DB;
    end
  end

  // restart all windows when the criteria change
  logic [1:0] cfg_d_reg;
  logic       cfg_chg;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) cfg_d_reg <= 2'b00;
    else         cfg_d_reg <= {line_rate_sel, los_standard_sel};
  end
  assign cfg_chg = cfg_d_reg != {line_rate_sel, los_standard_sel};

  // ***********************************************************
  // loss of signal
  // ***********************************************************
  lad_cnt_if #(.W(lad_pkg::CW)) dcl_c ();
  lad_cnt_if #(.W(lad_pkg::CW)) clr_c ();
  lad_cnt_if #(.W(lad_pkg::CW)) ais_c ();
  lad_win_cnt #(.W(lad_pkg::CW)) u_dcl (.mclk(mclk), .arst_n(arst_n), .c(dcl_c));
  lad_win_cnt #(.W(lad_pkg::CW)) u_clr (.mclk(mclk), .arst_n(arst_n), .c(clr_c));
  lad_win_cnt #(.W(lad_pkg::CW)) u_ais (.mclk(mclk), .arst_n(arst_n), .c(ais_c));

  // declare: silent low-level intervals in a row, any pulse restarts
  assign dcl_c.limit = n_lim;
  assign dcl_c.en    = rx_bit & below_q & ~mark_s & ~los_reg;
  assign dcl_c.clr   = pulse | ~below_q | los_reg | cfg_chg;

  // clear window opens on a received pulse
  logic       win_act_reg;
  logic [7:0] zrun_reg;
  logic [7:0] marks_reg;
  logic       abort;
  logic [lad_pkg::CW+lad_pkg::DENS_SH-1:0] dens;
  assign abort = win_act_reg & (~above_p | (rx_bit & ~mark_s & (zrun_reg + 8'h01 >= zrun_lim)));
  assign clr_c.limit = m_lim;
  assign clr_c.en    = rx_bit & win_act_reg;
  assign clr_c.clr   = ~win_act_reg | abort | cfg_chg;
  assign dens = {3'b000, 6'h00, marks_reg + 8'(pulse)} << lad_pkg::DENS_SH;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      win_act_reg <= 1'b0;
      zrun_reg    <= '0;
      marks_reg   <= '0;
    end else if (!los_reg || cfg_chg || abort || clr_c.done) begin
      win_act_reg <= 1'b0;
      zrun_reg    <= '0;
      marks_reg   <= '0;
    end else if (!win_act_reg) begin
      if (pulse && above_p) begin
        win_act_reg <= 1'b1;
        marks_reg   <= 8'h01;
        zrun_reg    <= '0;
      end
    end else if (rx_bit) begin
      zrun_reg  <= mark_s ? 8'h00 : zrun_reg + 8'h01;
      marks_reg <= (marks_reg == 8'hFF) ? marks_reg : marks_reg + 8'(mark_s);
    end
  end

  // loss state; the window pulse counts toward density
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      los_reg <= 1'b0;
    end else if (dcl_c.done) begin
      los_reg <= 1'b1;
    end else if (clr_c.done && dens >= {3'b000, m_lim}) begin
      los_reg <= 1'b0;
    end
  end

  // loss path ignores transmit and pattern settings, so loopbacks keep it
  assign loss_indicator_out = los_reg;
  assign loss_irq           = los_reg & ~loss_mask;

  // ***********************************************************
  // alarm indication
  // ***********************************************************
  logic [3:0] zeros_reg;
  logic [3:0] zeros_now;
  logic [3:0] zthr;
  logic       blk_low;
  logic       prev_low_reg;
  logic       prev_high_reg;
  logic       prev_ok_reg;
  assign zthr        = line_rate_sel ? lad_pkg::AIS_Z_T1 : lad_pkg::AIS_Z_E1;
  assign ais_c.limit = line_rate_sel ? lad_pkg::AIS_W_T1 : lad_pkg::AIS_W_E1;
  assign ais_c.en    = rx_bit & cdr_en;
  assign ais_c.clr   = ~cdr_en | cfg_chg;
  assign zeros_now   = (zeros_reg == 4'hF || mark_s) ? zeros_reg : zeros_reg + 4'h1;
  assign blk_low     = zeros_now < zthr;

  // block zero count, saturating well above either threshold
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      zeros_reg <= '0;
    end else if (ais_c.clr || ais_c.done) begin
      zeros_reg <= '0;
    end else if (ais_c.en) begin
      zeros_reg <= zeros_now;
    end
  end

  // E1 needs two blocks alike in a row; T1 decides on one block
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ais_reg       <= 1'b0;
      prev_low_reg  <= 1'b0;
      prev_high_reg <= 1'b0;
      prev_ok_reg   <= 1'b0;
    end else if (ais_c.clr) begin
      ais_reg       <= cdr_en ? ais_reg : 1'b0;
      prev_ok_reg   <= 1'b0;
      prev_low_reg  <= 1'b0;
      prev_high_reg <= 1'b0;
    end else if (ais_c.done) begin
      prev_ok_reg   <= 1'b1;
      prev_low_reg  <= blk_low;
      prev_high_reg <= ~blk_low;
      if (line_rate_sel) begin
        ais_reg <= blk_low;
      end else if (prev_ok_reg && blk_low && prev_low_reg) begin
        ais_reg <= 1'b1;
      end else if (prev_ok_reg && !blk_low && prev_high_reg) begin
        ais_reg <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // master-clock bit timebase
  // ***********************************************************
  logic [7:0] div_reg;
  logic [7:0] div_lim;
  logic       m_en;
  logic       mclk_div_reg;
  assign div_lim = line_rate_sel ? lad_pkg::DIV_T1 : lad_pkg::DIV_E1;
  // compare at or above so a rate change to a shorter divide never runs the count round
  assign m_en    = div_reg >= div_lim - 8'h01;

  // integer divide: a small rate offset traded for no fraction logic
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg      <= '0;
      mclk_div_reg <= 1'b0;
    end else begin
      div_reg      <= m_en ? 8'h00 : div_reg + 8'h01;
      mclk_div_reg <= div_reg < (div_lim >> 1);
    end
  end

  // ***********************************************************
  // receive system output
  // ***********************************************************
  logic rx_sub;
  assign rx_sub = los_reg & rx_alarm_insert_en;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_clk_out  <= 1'b0;
      rx_data_out <= 1'b0;
    end else begin
      rx_clk_out  <= rx_sub ? mclk_div_reg : rclk_s;
      if (rx_sub) begin
        rx_data_out <= 1'b1;
      end else if (rx_bit) begin
        rx_data_out <= mark_s;
      end
    end
  end

  // ***********************************************************
  // transmit pattern
  // ***********************************************************
  logic       tx_sub;
  logic       t_en;
  logic [14:0] prbs_reg;
  logic [2:0]  code_ptr_reg;
  assign tx_sub = los_reg & tx_alarm_insert_en;
  assign t_en   = (tx_sub | pattern_clk_sel) ? m_en : tx_en;

  // generators advance only on the chosen bit enable
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prbs_reg     <= lad_pkg::PRBS_SEED;
      code_ptr_reg <= 3'h7;
    end else if (t_en) begin
      if (pattern_sel == lad_pkg::LAD_PAT_PRBS) begin
        prbs_reg <= {prbs_reg[13:0], prbs_reg[14] ^ prbs_reg[13]};
      end
      code_ptr_reg <= code_ptr_reg - 3'h1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_line_pair <= 1'b0;
      tx_bit_stb   <= 1'b0;
    end else begin
      tx_bit_stb <= t_en;
      if (t_en) begin
        if (tx_sub) begin
          tx_line_pair <= 1'b1;
        end else begin
          case (pattern_sel)
            lad_pkg::LAD_PAT_NORM: tx_line_pair <= pattern_clk_sel ? 1'b0 : txd_s;
            lad_pkg::LAD_PAT_ONES: tx_line_pair <= 1'b1;
            lad_pkg::LAD_PAT_PRBS: tx_line_pair <= prbs_reg[14];
            lad_pkg::LAD_PAT_CODE: tx_line_pair <= code_reg[code_ptr_reg];
            default:               tx_line_pair <= txd_s;
          endcase
        end
      end
    end
  end
endmodule

// ==== verilog/lad_pkg.sv ====
// constants for the per-channel loss / alarm detector and transmit pattern block
// assumes one 200 MHz clock and classic wishbone register access
package lad_pkg;
  // ***********************************************************
  // register map (byte addresses)
  // ***********************************************************
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_CODE = 4'h4;
  localparam logic [3:0] ADR_STAT = 4'h8;
  // ctrl fields
  localparam int B_RATE   = 0;
  localparam int B_STD    = 1;
  localparam int B_EQ     = 2;
  localparam int B_CDR    = 3;
  localparam int B_RXINS  = 4;
  localparam int B_TXINS  = 5;
  localparam int B_PCLK   = 6;
  localparam int B_MASK   = 7;
  localparam int F_PAT    = 8;
  localparam int F_LVL    = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0008;
  localparam logic [7:0]  CODE_RST = 8'h00;
  // ***********************************************************
  // detection figures
  // ***********************************************************
  localparam int CW = 14;
  localparam logic [CW-1:0] N_T1_231  = 14'h00AF;
  localparam logic [CW-1:0] N_T1_431  = 14'h0608;
  localparam logic [CW-1:0] N_E1_775  = 14'h0020;
  localparam logic [CW-1:0] N_E1_431  = 14'h0800;
  localparam logic [CW-1:0] M_T1      = 14'h0080;
  localparam logic [CW-1:0] M_E1      = 14'h0020;
  localparam logic [7:0]    ZRUN_T1   = 8'h64;
  localparam logic [7:0]    ZRUN_E1   = 8'h10;
  localparam int            DENS_SH   = 3;
  localparam logic [CW-1:0] AIS_W_E1  = 14'h0200;
  localparam logic [CW-1:0] AIS_W_T1  = 14'h2000;
  localparam logic [3:0]    AIS_Z_E1  = 4'h3;
  localparam logic [3:0]    AIS_Z_T1  = 4'h9;
  // level thresholds, attenuation in dB or mVpp
  localparam logic [5:0] Q_BASE_DB  = 6'h04;
  localparam logic [5:0] Q_STEP_DB  = 6'h02;
  localparam logic [5:0] HYST_DB    = 6'h04;
  localparam logic [4:0] LVL_MAX    = 5'h0A;
  localparam logic [11:0] Q_FIX_MV  = 12'h320;
  localparam logic [11:0] HYST_MV   = 12'h0C8;
  // ***********************************************************
  // clocking
  // ***********************************************************
  localparam longint MCLK_HZ = 200000000;
  localparam longint E1_HZ   = 2048000;
  localparam longint T1_HZ   = 1544000;
  localparam logic [7:0] DIV_E1 = 8'(MCLK_HZ / E1_HZ);
  localparam logic [7:0] DIV_T1 = 8'(MCLK_HZ / T1_HZ);
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;
  // pattern select encoding
  typedef enum logic [1:0] {
    LAD_PAT_NORM = 2'b00,
    LAD_PAT_ONES = 2'b01,
    LAD_PAT_PRBS = 2'b10,
    LAD_PAT_CODE = 2'b11
  } lad_pat_e;
endpackage

// ==== verilog/lad_cnt_if.sv ====
// carrier between the detector and its bit-interval counters
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface lad_cnt_if #(parameter int W = 14);
  logic         clr;
  logic         en;
  logic [W-1:0] limit;
  logic [W-1:0] count;
  logic         done;
  modport owner (output clr, output en, output limit, input count, input done);
  modport cnt   (input clr, input en, input limit, output count, output done);
endinterface

// ==== verilog/lad_win_cnt.sv ====
// bit-interval window counter, wraps at its limit
// assumes the owner holds limit stable while counting
`timescale 1ns/1ps
module lad_win_cnt #(
  parameter int W = 14
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // counter carrier
  lad_cnt_if.cnt    c
);
  logic [W-1:0] count_reg;

  // refuse widths that cannot hold a start and a last interval
  if (W < 2) begin : g_bad_w
    $error("lad_win_cnt: width too small");
  end

  // done marks the last interval of a window
  assign c.done  = c.en & ~c.clr & (count_reg == c.limit - W'(1));
  assign c.count = count_reg;

  // clear has priority so a restart never leaks a stale count
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= '0;
    end else if (c.clr) begin
      count_reg <= '0;
    end else if (c.done) begin
      count_reg <= '0;
    end else if (c.en) begin
      count_reg <= count_reg + W'(1);
    end
  end
endmodule

// ==== dv/lad_chk.sv ====
// port assertions for the loss / pattern block
// assumes the single mclk domain; bound to every lad_top
`timescale 1ns/1ps
module lad_chk (
  // clock and reset
  input wire logic        mclk,
  input wire logic        arst_n,
  // bus handshake
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  // line side
  input wire logic        rx_data_rails_p,
  input wire logic        rx_data_rails_n,
  input wire logic        lvl_below_q,
  input wire logic        lvl_above_p,
  input wire logic [5:0]  q_atten_db,
  input wire logic [5:0]  p_atten_db,
  input wire logic [11:0] q_fixed_mv,
  input wire logic [11:0] p_fixed_mv,
  // status and transmit
  input wire logic        loss_indicator_out,
  input wire logic        loss_irq,
  input wire logic        tx_line_pair,
  input wire logic        tx_bit_stb
);
  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack late or too long");
  AST_IRQ: assert property (loss_irq |-> loss_indicator_out)
    else $error("irq without loss");
  // registered thresholds are valid only from the second edge
  AST_FIX_MV: assert property ($past(arst_n) |-> q_fixed_mv == 12'h320 && p_fixed_mv == 12'h3E8)
    else $error("fixed thresholds wrong");
  AST_P_DB: assert property ($past(arst_n) |-> p_atten_db + 6'h04 == q_atten_db && q_atten_db <= 6'h18)
    else $error("db thresholds wrong");
  AST_STB: assert property (tx_bit_stb |=> !tx_bit_stb)
    else $error("tx strobe too long");
  AST_TX_CHG: assert property ($changed(tx_line_pair) |-> tx_bit_stb)
    else $error("tx bit moved without strobe");
  AST_LOSS_UP: assert property ($rose(loss_indicator_out) |-> lvl_below_q && !rx_data_rails_p && !rx_data_rails_n)
    else $error("loss set on live line");
  AST_LOSS_DN: assert property ($fell(loss_indicator_out) |-> lvl_above_p && !lvl_below_q)
    else $error("loss cleared on weak line");
endmodule
bind lad_top lad_chk i_chk (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .rx_data_rails_p(rx_data_rails_p), .rx_data_rails_n(rx_data_rails_n),
  .lvl_below_q(lvl_below_q), .lvl_above_p(lvl_above_p), .q_atten_db(q_atten_db), .p_atten_db(p_atten_db),
  .q_fixed_mv(q_fixed_mv), .p_fixed_mv(p_fixed_mv), .loss_indicator_out(loss_indicator_out),
  .loss_irq(loss_irq), .tx_line_pair(tx_line_pair), .tx_bit_stb(tx_bit_stb));

// ==== dv/lad_line_model.sv ====
// line and system clock model facing the loss / pattern block
// assumes a 40 ns bit so that runs stay short
`timescale 1ns/1ps
module lad_line_model (
  // line condition chosen by the bench
  input wire logic silent,
  // receive line
  output logic     rx_rclk,
  output logic     rx_data_rails_p,
  output logic     rx_data_rails_n,
  output logic     lvl_below_q,
  output logic     lvl_above_p,
  // system transmit clock
  output logic     tx_clk
);
  logic pol = 1'b0;
  // idle line levels from time zero, so the block never samples unknown pins
  initial begin
    rx_data_rails_p = 1'b0;
    rx_data_rails_n = 1'b0;
    lvl_below_q     = 1'b0;
    lvl_above_p     = 1'b1;
  end
  // recovery holds its clock through silence, so it runs free
  always begin
    rx_rclk = 1'b0;
    #20;
    rx_rclk = 1'b1;
    #20;
  end
  // alternate marks on a live line, none and weak level when silent
  always @(negedge rx_rclk) begin
    pol <= ~pol;
    rx_data_rails_p <= ~silent & pol;
    rx_data_rails_n <= ~silent & ~pol;
    lvl_below_q <= silent;
    lvl_above_p <= ~silent;
  end
  always begin
    tx_clk = 1'b0;
    #30;
    tx_clk = 1'b1;
    #30;
  end
endmodule

// ==== dv/tb_los_ais_detect_pattern_tx.sv ====
// self-checking bench for the loss / pattern block
// assumes lad_line_model on the line side
`timescale 1ns/1ps
module tb_los_ais_detect_pattern_tx;
  localparam logic [3:0] A_CTRL = lad_pkg::ADR_CTRL;
  localparam logic [3:0] A_STAT = lad_pkg::ADR_STAT;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0, cyc_stb = 1'b0, we = 1'b0, silent = 1'b0, tx_data_in = 1'b0;
  logic        ack, rclk, rp, rn, bq, ap, tclk, rx_data_out, loss, irq, tx_line, stb;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, rd;
  logic [5:0]  qdb;
  logic        eqo, rxc;
  int          fails = 0, n_checks = 0, cyc = 0, hi_run = 0, hi_max = 0;
  lad_top i_dut (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(cyc_stb), .wb_stb_i(cyc_stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_rclk(rclk),
    .rx_data_rails_p(rp), .rx_data_rails_n(rn), .lvl_below_q(bq), .lvl_above_p(ap), .q_atten_db(qdb),
    .p_atten_db(), .q_fixed_mv(), .p_fixed_mv(), .eq_on_out(eqo), .rx_clk_out(rxc), .rx_data_out(rx_data_out),
    .loss_indicator_out(loss), .loss_irq(irq), .tx_clk(tclk), .tx_data_in(tx_data_in),
    .tx_line_pair(tx_line), .tx_bit_stb(stb));
  lad_line_model i_line (.silent(silent), .rx_rclk(rclk), .rx_data_rails_p(rp), .rx_data_rails_n(rn),
    .lvl_below_q(bq), .lvl_above_p(ap), .tx_clk(tclk));
  always #2.5 mclk = ~mclk;
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; ack is seen at the edge that ends it
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc_stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    rd = rdat;
    cyc_stb <= 1'b0;
  endtask
  // loss must change state inside a window of cycles
  task automatic wait_loss(input logic val, input int lo, input int hi);
    int n = 0;
    while (loss !== val && n < hi) begin
      @(posedge mclk);
      n++;
    end
    chk({31'h0, n >= lo && n < hi}, 32'h1);
  endtask
  // first two bits may still carry the old selection
  task automatic set_tx(input logic [31:0] ctrl, input logic exp);
    wb(1'b1, A_CTRL, ctrl);
    repeat (2) begin
      do @(posedge mclk); while (stb !== 1'b1);
    end
    repeat (3) begin
      do @(posedge mclk); while (stb !== 1'b1);
      chk({31'h0, tx_line}, {31'h0, exp});
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard; the sequence needs about 20000 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      summarize();
    end
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    wb(1'b0, A_CTRL, 32'h0);
    chk(rd, lad_pkg::CTRL_RST);
    wb(1'b1, 4'hC, 32'hFFFF_FFFF);
    wb(1'b0, 4'hC, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, A_STAT, 32'h0);
    chk(rd, 32'h0);
    // reserved level code must sit on the deepest step, code 3 three steps above the base
    wb(1'b1, A_CTRL, 32'h000B_000C);
    repeat (2) @(posedge mclk);
    chk({26'h0, qdb}, 32'h18);
    chk({31'h0, eqo}, 32'h1);
    wb(1'b1, A_CTRL, 32'h0003_0008);
    repeat (2) @(posedge mclk);
    chk({26'h0, qdb}, 32'h0A);
    $display("test registers done");
    silent <= 1'b1;
    wait_loss(1'b1, 240, 288);
    wb(1'b0, A_STAT, 32'h0);
    chk(rd, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, A_CTRL, 32'h18);
    repeat (20) @(posedge mclk);
    chk({31'h0, rx_data_out}, 32'h1);
    // master-derived clock stays high far longer than the 4-cycle recovered one
    repeat (150) begin
      @(posedge mclk);
      hi_run = (rxc === 1'b1) ? hi_run + 1 : 0;
      if (hi_run > hi_max) hi_max = hi_run;
    end
    chk({31'h0, hi_max > 24}, 32'h1);
    wb(1'b1, A_CTRL, 32'h88);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    set_tx(32'h28, 1'b1);
    wb(1'b1, A_CTRL, 32'h08);
    silent <= 1'b0;
    wait_loss(1'b0, 240, 288);
    $display("test e1 loss done");
    set_tx(32'h008, 1'b0);
    set_tx(32'h108, 1'b1);
    set_tx(32'h148, 1'b1);
    tx_data_in <= 1'b1;
    set_tx(32'h048, 1'b0);
    set_tx(32'h008, 1'b1);
    wb(1'b1, lad_pkg::ADR_CODE, 32'h0000_00A5);
    wb(1'b0, lad_pkg::ADR_CODE, 32'h0);
    chk(rd, 32'hA5);
    wb(1'b1, lad_pkg::ADR_CODE, 32'h0);
    // an all-zero code must override the ones on the data input
    set_tx(32'h308, 1'b0);
    // generator starts from its all-ones seed, so its first bits are ones
    set_tx(32'h208, 1'b1);
    $display("test patterns done");
    wb(1'b1, A_CTRL, 32'h09);
    silent <= 1'b1;
    wait_loss(1'b1, 1376, 1440);
    silent <= 1'b0;
    wait_loss(1'b0, 1008, 1072);
    $display("test t1 loss done");
    wb(1'b1, A_CTRL, 32'h08);
    repeat (13000) @(posedge mclk);
    wb(1'b0, A_STAT, 32'h0);
    chk(rd, 32'h2);
    wb(1'b1, A_CTRL, 32'h00);
    repeat (4) @(posedge mclk);
    wb(1'b0, A_STAT, 32'h0);
    chk(rd, 32'h0);
    $display("test alarm done");
    summarize();
  end
endmodule
